// ---- inc/framer_pkg.sv ----
// Constants, register map and carrier types of the burst shifter framer
package framer_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_OUTPUT_ROUTING = 8'hDD;
	localparam logic [7:0] ADDR_SHIFT_DATA     = 8'hE0;
	localparam logic [7:0] ADDR_DIVIDE_LENGTH  = 8'hE1;
	localparam logic [7:0] ADDR_MODE_CONTROL   = 8'hE2;
	localparam logic [7:0] ADDR_PORT_C_CONFIG  = 8'hC4;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MODE_RUN_BIT        = 7;
	localparam int MODE_IRQ_EN_BIT     = 6;
	localparam int MODE_INT_CLK_BIT    = 4;
	localparam int DIV_FIELD_LSB       = 0;
	localparam int DIV_FIELD_MSB       = 2;
	localparam int LEN_FIELD_LSB       = 3;
	localparam int LEN_FIELD_MSB       = 6;
	localparam int PORT_OUT_BIT        = 0;
	localparam int PORT_EDGE_EN_BIT    = 1;
	localparam int PORT_SIN_LEVEL_BIT  = 2;

	// ----------------------------------------------------------------
	// Reset and special values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_OUTPUT_ROUTING  = 8'h00;
	localparam logic [7:0] RST_SHIFT_DATA      = 8'hFF;
	localparam logic [7:0] RST_DIVIDE_LENGTH   = 8'h3E;
	localparam logic [7:0] RST_MODE_CONTROL    = 8'h00;
	localparam logic [1:0] RST_PORT_C_CONFIG   = 2'h1;
	localparam logic [7:0] ROUTE_TO_SHIFTER    = 8'h01;
	localparam logic [7:0] READ_ZERO           = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLOCK_HZ         = 25_000_000;
	localparam logic [11:0] CORE_DIVIDE      = 12'h00D;
	localparam logic [11:0] FIRST_EDGE_OSC   = 12'h009;
	localparam logic [11:0] FIRST_EDGE_LOAD  = FIRST_EDGE_OSC - 12'h001;

	localparam logic [2:0] DIV_CODE_1   = 3'h0;
	localparam logic [2:0] DIV_CODE_2   = 3'h1;
	localparam logic [2:0] DIV_CODE_4   = 3'h2;
	localparam logic [2:0] DIV_CODE_8   = 3'h3;
	localparam logic [2:0] DIV_CODE_16  = 3'h4;
	localparam logic [2:0] DIV_CODE_32  = 3'h5;
	localparam logic [2:0] DIV_CODE_64  = 3'h6;
	localparam logic [8:0] RATIO_1      = 9'h001;
	localparam logic [8:0] RATIO_2      = 9'h002;
	localparam logic [8:0] RATIO_4      = 9'h004;
	localparam logic [8:0] RATIO_8      = 9'h008;
	localparam logic [8:0] RATIO_16     = 9'h010;
	localparam logic [8:0] RATIO_32     = 9'h020;
	localparam logic [8:0] RATIO_64     = 9'h040;
	localparam logic [8:0] RATIO_256    = 9'h100;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_type;

	typedef enum logic [0:0] {
		SH_IDLE = 1'b0,
		SH_RUN  = 1'b1
	} shift_state_type;

endpackage

// ---- hw/spi_burst_uart_framer.sv ----
// Master-mode burst shifter used as an asynchronous serial framer
`timescale 1ns/1ps
`default_nettype none

module spi_burst_uart_framer (
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	input  wire framer_pkg::reg_req_type bus_req,
	output logic [7:0]                  rdata_ff,
	input  wire logic                   serial_in,
	output logic                        serial_out_ff,
	output logic                        shift_clock_ff,
	output logic                        vector_two_request_ff
);

	// ----------------------------------------------------------------
	// Input synchroniser
	// ----------------------------------------------------------------
	logic sin_meta_ff;
	logic sin_sync_ff;
	logic sin_prev_ff;
	// Idle-high reset keeps the edge detector from a false start edge

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sin_meta_ff <= 1'b1;
			sin_sync_ff <= 1'b1;
			sin_prev_ff <= 1'b1;
		end else begin
			sin_meta_ff <= serial_in;
			sin_sync_ff <= sin_meta_ff;
			sin_prev_ff <= sin_sync_ff;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]                  routing_ff;
	logic [7:0]                  shift_ff;
	logic [7:0]                  divide_ff;
	logic [7:0]                  mode_ff;
	logic [1:0]                  port_cfg_ff;
	framer_pkg::shift_state_type state_ff;
	logic [11:0]                 phase_ff;
	logic [3:0]                  bits_left_ff;
	logic                        sample_ff;

	logic [7:0]                  nxt_shift;
	logic [7:0]                  nxt_mode;
	framer_pkg::shift_state_type nxt_state;
	logic [11:0]                 nxt_phase;
	logic [3:0]                  nxt_bits_left;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire sel_routing = bus_req.addr == framer_pkg::ADDR_OUTPUT_ROUTING;
	wire sel_shift   = bus_req.addr == framer_pkg::ADDR_SHIFT_DATA;
	wire sel_divide  = bus_req.addr == framer_pkg::ADDR_DIVIDE_LENGTH;
	wire sel_mode    = bus_req.addr == framer_pkg::ADDR_MODE_CONTROL;
	wire sel_port    = bus_req.addr == framer_pkg::ADDR_PORT_C_CONFIG;
	wire running     = state_ff == framer_pkg::SH_RUN;

	// Shift, divide and mode writes during a burst are ignored so the frame stays coherent
	wire wr_routing  = bus_req.wr && sel_routing;
	wire wr_shift    = bus_req.wr && sel_shift && !running;
	wire wr_divide   = bus_req.wr && sel_divide && !running;
	wire wr_mode     = bus_req.wr && sel_mode && !running;
	wire wr_port     = bus_req.wr && sel_port;

	// ----------------------------------------------------------------
	// Bit timing
	// ----------------------------------------------------------------
	wire [2:0] div_field = divide_ff[framer_pkg::DIV_FIELD_MSB:framer_pkg::DIV_FIELD_LSB];
	wire [3:0] len_field = divide_ff[framer_pkg::LEN_FIELD_MSB:framer_pkg::LEN_FIELD_LSB];
	logic [8:0] ratio;

	always_comb begin
		case (div_field)
			framer_pkg::DIV_CODE_1: begin
				ratio = framer_pkg::RATIO_1;
			end
			framer_pkg::DIV_CODE_2: begin
				ratio = framer_pkg::RATIO_2;
			end
			framer_pkg::DIV_CODE_4: begin
				ratio = framer_pkg::RATIO_4;
			end
			framer_pkg::DIV_CODE_8: begin
				ratio = framer_pkg::RATIO_8;
			end
			framer_pkg::DIV_CODE_16: begin
				ratio = framer_pkg::RATIO_16;
			end
			framer_pkg::DIV_CODE_32: begin
				ratio = framer_pkg::RATIO_32;
			end
			framer_pkg::DIV_CODE_64: begin
				ratio = framer_pkg::RATIO_64;
			end
			default: begin
				ratio = framer_pkg::RATIO_256;
			end
		endcase
	end

	// Counting in osc cycles splits the odd 13-cycle period of ratio 1 into 7 high and 6 low
	wire [20:0] bit_product = 21'(framer_pkg::CORE_DIVIDE) * 21'(ratio);
	wire [11:0] bit_cycles  = bit_product[11:0];
	wire [11:0] bit_last    = bit_cycles - 12'h001;
	wire [11:0] bit_half    = {1'b0, bit_cycles[11:1]};
	wire        rise_now    = running && phase_ff == bit_last;
	wire        fall_now    = running && phase_ff == bit_half && shift_clock_ff;

	// ----------------------------------------------------------------
	// Burst start and finish
	// ----------------------------------------------------------------
	wire master_mode = mode_ff[framer_pkg::MODE_INT_CLK_BIT] |
	                   bus_req.wdata[framer_pkg::MODE_INT_CLK_BIT];
	wire start_req   = wr_mode && bus_req.wdata[framer_pkg::MODE_RUN_BIT];
	// Single shifter: a new burst is only taken while idle
	wire start_burst = start_req && master_mode && !running;
	wire last_fall   = fall_now && bits_left_ff == 4'h1;
	wire empty_burst = start_burst && len_field == 4'h0;
	wire burst_done  = last_fall || empty_burst;

	always_comb begin
		nxt_state     = state_ff;
		nxt_phase     = phase_ff;
		nxt_bits_left = bits_left_ff;
		// Preload so the first rise lands nine clocks after the run write
		if (start_burst && !empty_burst) begin
			nxt_state     = framer_pkg::SH_RUN;
			nxt_phase     = bit_last - framer_pkg::FIRST_EDGE_LOAD;
			nxt_bits_left = len_field;
		end else if (running) begin
			nxt_phase = rise_now ? 12'h000 : phase_ff + 12'h001;
			if (fall_now) begin
				nxt_bits_left = bits_left_ff - 4'h1;
			end
			if (last_fall) begin
				nxt_state = framer_pkg::SH_IDLE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Shift register and mode register
	// ----------------------------------------------------------------
	always_comb begin
		nxt_shift = shift_ff;
		if (wr_shift) begin
			nxt_shift = bus_req.wdata;
		end else if (fall_now) begin
			// Bit 7 leaves first, the sampled input enters bit 0
			nxt_shift = {shift_ff[6:0], sample_ff};
		end
	end

	always_comb begin
		nxt_mode = mode_ff;
		if (wr_mode) begin
			nxt_mode = bus_req.wdata;
			nxt_mode[framer_pkg::MODE_RUN_BIT] = start_burst && !empty_burst;
		end else if (last_fall) begin
			nxt_mode[framer_pkg::MODE_RUN_BIT] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			routing_ff  <= framer_pkg::RST_OUTPUT_ROUTING;
			shift_ff    <= framer_pkg::RST_SHIFT_DATA;
			divide_ff   <= framer_pkg::RST_DIVIDE_LENGTH;
			mode_ff     <= framer_pkg::RST_MODE_CONTROL;
			port_cfg_ff <= framer_pkg::RST_PORT_C_CONFIG;
		end else begin
			if (wr_routing) begin
				routing_ff <= bus_req.wdata;
			end
			if (wr_divide) begin
				divide_ff <= bus_req.wdata;
			end
			if (wr_port) begin
				port_cfg_ff <= bus_req.wdata[1:0];
			end
			shift_ff <= nxt_shift;
			mode_ff  <= nxt_mode;
		end
	end

	// ----------------------------------------------------------------
	// Burst sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_ff     <= framer_pkg::SH_IDLE;
			phase_ff     <= 12'h000;
			bits_left_ff <= 4'h0;
			sample_ff    <= 1'b1;
		end else begin
			state_ff     <= nxt_state;
			phase_ff     <= nxt_phase;
			bits_left_ff <= nxt_bits_left;
			// Sampling at the rise leaves half a bit before the shift
			if (rise_now) begin
				sample_ff <= sin_sync_ff;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	wire route_shift  = routing_ff == framer_pkg::ROUTE_TO_SHIFTER;
	wire port_bit     = port_cfg_ff[framer_pkg::PORT_OUT_BIT];
	// Shifter path shows bit 7 even between bursts to pre-position data
	wire nxt_sout     = route_shift ? nxt_shift[7] : port_bit;
	wire sin_fall     = sin_prev_ff && !sin_sync_ff;
	wire edge_irq     = sin_fall && port_cfg_ff[framer_pkg::PORT_EDGE_EN_BIT];
	// Edge and done requests share one pulse; no sticky status kept
	wire done_irq     = last_fall && mode_ff[framer_pkg::MODE_IRQ_EN_BIT];

	logic nxt_sck;

	always_comb begin
		nxt_sck = shift_clock_ff;
		if (rise_now) begin
			nxt_sck = 1'b1;
		end else if (fall_now || !running) begin
			nxt_sck = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			serial_out_ff         <= 1'b1;
			shift_clock_ff        <= 1'b0;
			vector_two_request_ff <= 1'b0;
		end else begin
			serial_out_ff         <= nxt_sout;
			shift_clock_ff        <= nxt_sck;
			vector_two_request_ff <= edge_irq || done_irq;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Read data lasts one cycle, then returns to zero
	wire [7:0] port_view = {5'h00, sin_sync_ff, port_cfg_ff};
	wire [7:0] read_mux  = sel_routing ? routing_ff :
	                       sel_shift   ? shift_ff :
	                       sel_divide  ? divide_ff :
	                       sel_mode    ? mode_ff :
	                       sel_port    ? port_view :
	                       framer_pkg::READ_ZERO;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_ff <= framer_pkg::READ_ZERO;
		end else begin
			rdata_ff <= bus_req.rd ? read_mux : framer_pkg::READ_ZERO;
		end
	end

	// Unused field bits are stored but steer nothing
	wire unused_ok = &{1'b0, divide_ff[7], burst_done};

endmodule

`default_nettype wire

// ---- sim/framer_checker_assertions.sv ----
// Checker of shift clock, routing and request timing of the framer
`timescale 1ns/1ps
`default_nettype none
module framer_checker (
	input wire logic                    clock,
	input wire logic                    rst_n,
	input wire framer_pkg::reg_req_type bus_req,
	input wire logic                    serial_in,
	input wire logic                    serial_out_ff,
	input wire logic                    shift_clock_ff,
	input wire logic                    vector_two_request_ff
);
	// --------
	// Mirror of the configuration
	// --------
	logic [7:0] div_ff;
	logic       mode4_ff;
	logic       edge_en_ff;
	logic       port_ff;
	logic       route_ff;
	int         since_ff;
	int         first_ff;
	int         rises_ff;
	int         per;
	wire        run_wr = bus_req.wr && bus_req.addr == 8'hE2 && bus_req.wdata[7];
	wire        start = run_wr && (bus_req.wdata[4] || mode4_ff) && div_ff[6:3] != 4'h0;
	assign per = 13 * (div_ff[2:0] == 3'h7 ? 256 : 1 << div_ff[2:0]);

	// Counting from the start write keeps the check valid for any ratio
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			div_ff <= 8'h3E;
			mode4_ff <= 1'b0;
			edge_en_ff <= 1'b0;
			port_ff <= 1'b1;
			route_ff <= 1'b0;
			since_ff <= 0;
			first_ff <= 0;
			rises_ff <= 0;
		end else begin
			since_ff <= start ? 0 : since_ff + 1;
			if (start) begin
				rises_ff <= 0;
			end else if ($rose(shift_clock_ff)) begin
				rises_ff <= rises_ff + 1;
			end
			if ($rose(shift_clock_ff) && rises_ff == 0) begin
				first_ff <= since_ff;
			end
			if (bus_req.wr && bus_req.addr == 8'hE1) begin
				div_ff <= bus_req.wdata;
			end
			if (bus_req.wr && bus_req.addr == 8'hE2) begin
				mode4_ff <= bus_req.wdata[4];
			end
			if (bus_req.wr && bus_req.addr == 8'hC4) begin
				edge_en_ff <= bus_req.wdata[1];
				port_ff <= bus_req.wdata[0];
			end
			if (bus_req.wr && bus_req.addr == 8'hDD) begin
				route_ff <= bus_req.wdata == 8'h01;
			end
		end
	end

	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	AST_FIRST_EDGE: assert property (start |=> !shift_clock_ff [*8] ##[1:3] $rose(shift_clock_ff))
		else $error("first shift edge off");
	AST_RISE_PERIOD: assert property ($rose(shift_clock_ff) && rises_ff > 0 |-> (since_ff - first_ff) % per == 0)
		else $error("shift clock period wrong");
	// High phase is half a period plus the cycle of the fall decision
	AST_FALL_HALF: assert property ($fell(shift_clock_ff) |-> (since_ff - first_ff) % per == per / 2 + 1)
		else $error("shift clock fall misplaced");
	AST_BURST_LEN: assert property ($rose(shift_clock_ff) |-> rises_ff < div_ff[6:3])
		else $error("too many shift edges");
	AST_NO_MASTER: assert property (run_wr && !bus_req.wdata[4] && !mode4_ff |=> !shift_clock_ff [*8])
		else $error("clock without master mode");
	AST_EDGE_REQ: assert property ($fell(serial_in) && edge_en_ff |-> ##[1:5] vector_two_request_ff)
		else $error("no request on input edge");
	AST_ROUTE_PORT: assert property (!$past(route_ff) |-> serial_out_ff == $past(port_ff))
		else $error("output not from port bit");
	AST_RESET_IDLE: assert property (!$past(rst_n) |-> serial_out_ff && !shift_clock_ff && !vector_two_request_ff)
		else $error("lines not idle after reset");
endmodule

bind spi_burst_uart_framer framer_checker checker_i (.clock(clock), .rst_n(rst_n), .bus_req(bus_req),
	.serial_in(serial_in), .serial_out_ff(serial_out_ff), .shift_clock_ff(shift_clock_ff),
	.vector_two_request_ff(vector_two_request_ff));
`default_nettype wire

// ---- sim/far_serial_model.sv ----
// Model of the far asynchronous serial chip
`timescale 1ns/1ps
`default_nettype none
module far_serial_model #(
	parameter int PER = 104
) (
	input  wire logic  clock,
	input  wire logic  line_in,
	output logic       line_out,
	output logic [9:0] rx_word,
	output int         rx_count
);
	// --------
	// Sender and listener
	// --------
	task automatic send(input logic [8:0] v);
		line_out <= 1'b0;
		repeat (PER) @(posedge clock);
		for (int i = 0; i < 9; i++) begin
			line_out <= v[i];
			repeat (PER) @(posedge clock);
		end
		line_out <= 1'b1;
	endtask

	// Idle line is driven high from time zero
	initial begin
		line_out = 1'b1;
		rx_word = 10'h000;
		rx_count = 0;
		forever begin
			@(negedge line_in);
			repeat (PER / 2) @(posedge clock);
			if (line_in === 1'b0) begin
				for (int i = 0; i < 10; i++) begin
					repeat (PER) @(posedge clock);
					rx_word[i] = line_in;
				end
				rx_count++;
			end
		end
	end
endmodule
`default_nettype wire

// ---- sim/spi_burst_uart_framer_tb.sv ----
// Register-level tests of the framer against a far serial chip
`timescale 1ns/1ps
`default_nettype none
module spi_burst_uart_framer_tb;
	// Ratio 32: one bit is 13 * 32 clocks
	localparam int PER = 416;
	logic                    clock;
	logic                    rst_n;
	framer_pkg::reg_req_type req;
	logic [7:0]              rdata_ff;
	logic                    serial_in;
	logic                    serial_out_ff;
	logic                    shift_clock_ff;
	logic                    vector_two_request_ff;
	logic [9:0]              rx_word;
	int                      rx_count;
	int                      fail_count;
	int                      n_tests;
	int                      k;
	logic [7:0]              q;
	logic [7:0]              d;
	logic [7:0]              e;
	logic                    n;
	logic [7:0]              ra [6] = '{8'hDD, 8'hE0, 8'hE1, 8'hE2, 8'hC4, 8'h10};
	logic [7:0]              rv [6] = '{8'h00, 8'hFF, 8'h3E, 8'h00, 8'h05, 8'h00};

	spi_burst_uart_framer dut (.clock(clock), .rst_n(rst_n), .bus_req(req), .rdata_ff(rdata_ff),
		.serial_in(serial_in), .serial_out_ff(serial_out_ff), .shift_clock_ff(shift_clock_ff),
		.vector_two_request_ff(vector_two_request_ff));
	far_serial_model #(.PER(PER)) partner (.clock(clock), .line_in(serial_out_ff), .line_out(serial_in),
		.rx_word(rx_word), .rx_count(rx_count));

	// --------
	// Bus access, compare and closing
	// --------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// The idle cycle after each strobe avoids a double drive at one edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
		req.addr <= a;
		req.wdata <= wd;
		req.wr <= w;
		req.rd <= !w;
		@(posedge clock);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		@(negedge clock);
		q = rdata_ff;
		@(posedge clock);
	endtask

	task automatic idle_wait;
		k = 0;
		do begin
			bus(1'b0, 8'hE2, 8'h00);
			k++;
		end while (q[7] !== 1'b0 && k < 4000);
	endtask

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		final_report;
	end

	initial begin
		rst_n = 1'b0;
		req = 18'h00000;
		fail_count = 0;
		n_tests = 0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 8'h00);
			chk("reset value", rv[i], q);
		end
		bus(1'b1, 8'hE2, 8'h80);
		bus(1'b0, 8'hE2, 8'h00);
		chk("run without master", 8'h00, q);
		bus(1'b1, 8'hE2, 8'h18);
		bus(1'b1, 8'hE1, 8'h3D);
		bus(1'b0, 8'hE2, 8'h00);
		chk("mode", 8'h18, q);
		bus(1'b0, 8'hE1, 8'h00);
		chk("divide", 8'h3D, q);
		// Receive a frame in a seven and a three bit burst
		d = 8'hA5;
		n = 1'b0;
		bus(1'b1, 8'hDD, 8'h01);
		bus(1'b1, 8'hC4, 8'h03);
		fork
			partner.send({n, d});
		join_none
		k = 0;
		while (vector_two_request_ff !== 1'b1 && k < 400) begin
			@(negedge clock);
			k++;
		end
		chk("edge request", 1'b1, vector_two_request_ff);
		@(posedge clock);
		bus(1'b1, 8'hC4, 8'h01);
		repeat (3 * PER / 2 - 18) @(posedge clock);
		bus(1'b1, 8'hE2, 8'h98);
		idle_wait;
		chk("run cleared", 8'h18, q);
		bus(1'b0, 8'hE0, 8'h00);
		for (int i = 0; i < 7; i++) e[6 - i] = d[i];
		e[7] = 1'b1;
		chk("first burst", e, q);
		bus(1'b1, 8'hE0, 8'hFF);
		bus(1'b1, 8'hE1, 8'h1D);
		repeat (PER / 2 - 20) @(posedge clock);
		bus(1'b1, 8'hE2, 8'h98);
		idle_wait;
		bus(1'b0, 8'hE0, 8'h00);
		chk("second burst", {5'h1F, d[7], n, 1'b1}, q);
		chk("no echo", 0, rx_count);
		// Send a frame, start bit from the port bit
		d = 8'h3C;
		n = 1'b1;
		bus(1'b1, 8'hDD, 8'h00);
		bus(1'b1, 8'hC4, 8'h00);
		for (int i = 0; i < 8; i++) e[7 - i] = d[i];
		bus(1'b1, 8'hE0, e);
		bus(1'b1, 8'hE1, 8'h3D);
		repeat (PER - 6) @(posedge clock);
		bus(1'b1, 8'hDD, 8'h01);
		repeat (PER / 2 - 13) @(posedge clock);
		bus(1'b1, 8'hE2, 8'h98);
		idle_wait;
		bus(1'b1, 8'hE0, {d[7], n, 6'h3F});
		bus(1'b1, 8'hE1, 8'h1D);
		repeat (PER / 2 - 19) @(posedge clock);
		bus(1'b1, 8'hE2, 8'h98);
		idle_wait;
		bus(1'b1, 8'hC4, 8'h01);
		repeat (2 * PER) @(posedge clock);
		chk("sent frame", {1'b1, n, d}, rx_word);
		chk("frames heard", 1, rx_count);
		final_report;
	end
endmodule
`default_nettype wire
